/* tmr16_pwm.v */
// 16-bit timer with clear-on-match and fast pwm modes
`timescale 1ns/1ps
`include "tmr16_consts.vh"
module tmr16_pwm #(
    parameter W = 16
) (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    output wire OUT_A,
    output wire OUT_A_OE_N,
    output wire OUT_B,
    output wire OUT_B_OE_N
);
    reg [15:0] ctrl_r;
    reg [W-1:0] cnt_r, cmpa_r, cmpa_buf_r, cmpb_r, cap_r;
    reg [3:0] flags_r;
    reg oa_r, ob_r;
    reg [9:0] pre_r;
    wire [3:0] mode = ctrl_r[`CTRL_MODE_LSB +: 4];
    wire [2:0] cs = ctrl_r[`CTRL_CS_LSB +: 3];
    wire [1:0] acta = ctrl_r[`CTRL_ACTA_LSB +: 2];
    wire [1:0] actb = ctrl_r[`CTRL_ACTB_LSB +: 2];

    // fast pwm mode decode
    function is_fast;
        input [3:0] m;
        begin
            is_fast = (m == `MODE_F8) || (m == `MODE_F9) ||
                (m == `MODE_F10) || (m == `MODE_FCAP) || (m == `MODE_FA);
        end
    endfunction

    // fixed-top mask for compare writes
    function [15:0] fix_mask;
        input [3:0] m;
        begin
            case (m)
                `MODE_F8: fix_mask = `TOP_8;
                `MODE_F9: fix_mask = `TOP_9;
                `MODE_F10: fix_mask = `TOP_10;
                default: fix_mask = `CNT_MAX;
            endcase
        end
    endfunction

    wire fast = is_fast(mode);
    wire clear_on_match_mode = (mode == `MODE_CTC_A) || (mode == `MODE_CTC_C);

    // ****************************************
    // prescaler
    // ****************************************
    // tick from prescaler
    reg tick;
    always @* begin
        case (cs)
            3'h1: tick = 1'b1;
            // low divider bits all ones marks the end of a period
            3'h2: tick = ((pre_r & `DIV_8) == `DIV_8);
            3'h3: tick = ((pre_r & `DIV_64) == `DIV_64);
            3'h4: tick = ((pre_r & `DIV_256) == `DIV_256);
            3'h5: tick = (pre_r == `DIV_1024);
            default: tick = 1'b0;
        endcase
    end

    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N)
            pre_r <= 10'h000;
        else if (cs == 3'h0)
            pre_r <= 10'h000;
        else
            pre_r <= pre_r + 10'h001;
    end

    // ****************************************
    // top select and match
    // ****************************************
    // top per mode
    reg [W-1:0] top;
    always @* begin
        case (mode)
            `MODE_F8: top = `TOP_8;
            `MODE_F9: top = `TOP_9;
            `MODE_F10: top = `TOP_10;
            `MODE_FCAP, `MODE_CTC_C: top = cap_r;
            `MODE_FA, `MODE_CTC_A: top = cmpa_r;
            default: top = `CNT_MAX;
        endcase
    end

    // exact equality, so a low top wraps through MAX
    wire at_top = (cnt_r == top);
    wire at_max = (cnt_r == `CNT_MAX);
    wire ma = (cnt_r == cmpa_r);
    wire mb = (cnt_r == cmpb_r);
    wire top_a = (mode == `MODE_FA) || (mode == `MODE_CTC_A);
    wire top_c = (mode == `MODE_FCAP) || (mode == `MODE_CTC_C);
    wire wr_cnt = WR && (ADDR == `OFS_CNT);
    wire wr_flg = WR && (ADDR == `OFS_FLAGS);
    wire frc = WR && (ADDR == `OFS_FORCE) && !fast;

    // ****************************************
    // counter and compare registers
    // ****************************************
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cnt_r <= 16'h0000;
            cmpa_r <= 16'h0000;
            cmpa_buf_r <= 16'h0000;
            cmpb_r <= 16'h0000;
            cap_r <= 16'h0000;
            ctrl_r <= `CTRL_RESET;
        end else begin
            if (WR && ADDR == `OFS_CTRL)
                ctrl_r <= WDATA;
            // capture write takes effect at once
            if (WR && ADDR == `OFS_CAP)
                cap_r <= WDATA;
            if (WR && ADDR == `OFS_CMPB)
                cmpb_r <= WDATA & fix_mask(mode);
            if (WR && ADDR == `OFS_CMPA) begin
                cmpa_buf_r <= WDATA & fix_mask(mode);
                if (!fast)
                    cmpa_r <= WDATA & fix_mask(mode);
            end
            if (wr_cnt)
                cnt_r <= WDATA;
            else if (tick) begin
                // clear after top, else count up
                if ((fast || clear_on_match_mode) && at_top)
                    cnt_r <= 16'h0000;
                else
                    cnt_r <= cnt_r + 16'h0001;
                // buffered compare A loads at top
                if (fast && at_top && !(WR && ADDR == `OFS_CMPA))
                    cmpa_r <= cmpa_buf_r;
            end
        end
    end

    // ****************************************
    // flags
    // ****************************************
    // flag sources; set wins over clear
    reg [3:0] fset;
    always @* begin
        fset = 4'h0;
        if (tick) begin
            fset[`FLG_CMPA] = ma;
            fset[`FLG_CMPB] = mb;
            if (fast)
                fset[`FLG_OVF] = at_top;
            else
                fset[`FLG_OVF] = at_max;
            if ((fast || clear_on_match_mode) && at_top) begin
                if (top_a)
                    fset[`FLG_CMPA] = 1'b1;
                if (top_c)
                    fset[`FLG_CAP] = 1'b1;
            end
        end
    end

    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N)
            flags_r <= 4'h0;
        else if (wr_flg)
            flags_r <= (flags_r & ~WDATA[3:0]) | fset;  // write one to clear
        else
            flags_r <= flags_r | fset;
    end

    // ****************************************
    // waveform outputs
    // ****************************************
    // next value of one channel
    function wave_nxt;
        input cur, match, bottom, force_it, fst;
        input [1:0] act;
        begin
            wave_nxt = cur;
            if (fst) begin
                // pwm set/clear; match wins at top
                if (act[1]) begin
                    // non-inverted sets at bottom, inverted clears
                    if (bottom)
                        wave_nxt = ~act[0];
                    // non-inverted clears on match, inverted sets
                    if (match)
                        wave_nxt = act[0];
                end
            end else if (match || force_it) begin
                case (act)
                    2'h1: wave_nxt = ~cur;
                    2'h2: wave_nxt = 1'b0;
                    2'h3: wave_nxt = 1'b1;
                    default: wave_nxt = cur;
                endcase
            end
        end
    endfunction

    // toggle on A; rate from top and tick
    wire tog_a = tick && ma;
    wire bot = tick && fast && at_top;
    wire [1:0] acta_f = (fast && acta == 2'h1) ? 2'h0 : acta;
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            oa_r <= 1'b0;
            ob_r <= 1'b0;
        end else begin
            if (fast && acta == 2'h1 && mode == `MODE_FA && tog_a)
                oa_r <= ~oa_r;
            else
                oa_r <= wave_nxt(oa_r, tog_a, bot,
                    frc && WDATA[0], fast, acta_f);
            ob_r <= wave_nxt(ob_r, tick && mb, bot,
                frc && WDATA[1], fast, actb);
        end
    end

    // pin driven only with direction bit set
    assign OUT_A = oa_r;
    assign OUT_B = ob_r;
    assign OUT_A_OE_N = ~(ctrl_r[`CTRL_DIRA_BIT] && acta != 2'h0);
    assign OUT_B_OE_N = ~(ctrl_r[`CTRL_DIRB_BIT] && actb != 2'h0);

    // ****************************************
    // read port
    // ****************************************
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N)
            RDATA <= 16'h0000;
        else if (RD) begin
            case (ADDR)
                `OFS_CTRL: RDATA <= ctrl_r;
                `OFS_CNT: RDATA <= cnt_r;
                `OFS_CMPA: RDATA <= fast ? cmpa_buf_r : cmpa_r;
                `OFS_CMPB: RDATA <= cmpb_r;
                `OFS_CAP: RDATA <= cap_r;
                `OFS_FLAGS: RDATA <= {12'h000, flags_r};
                default: RDATA <= 16'h0000;
            endcase
        end else
            RDATA <= 16'h0000;
    end
endmodule

/* tmr16_consts.vh */
// constants for the 16-bit clear-on-match / fast pwm timer
// Function
// - modes 4 and 12 clear counter on match with compare A or capture.
// - clear-on-match top is unbuffered; low new top wraps via 0xFFFF.
// - clear-on-match sets compare A or capture flag at top.
// - clear-on-match with action 1 toggles channel A on each match.
// - channel A reaches the pin only when its direction bit is 1.
// - clear-on-match toggle frequency is clk over 2*N*(1+top), top being compare A (mode 4) or capture (mode 12).
// - clear-on-match sets overflow flag when counter rolls MAX to zero.
// - fast pwm modes count up only, clear cycle after top.
// - fast pwm top is 0xFF, 0x1FF, 0x3FF, capture or compare A.
// - action two is non-inverted, three is inverted pwm.
// - non-inverted clears on match, sets at bottom; inverted opposite.
// - fast pwm sets overflow at top, plus compare A or capture flag when that register is top.
// - channel compare flag sets whenever count equals its compare value.
// - fixed top masks compare write bits above the resolution.
// - fast pwm compare A is buffered, loaded at top with clear.
// - capture writes act at once; low value wraps through MAX.
// - compare zero gives narrow spike, compare top constant level.
// - mode 15 with action 1 toggles channel A, 50 percent duty.
// - fast pwm frequency is clk over N*(1+top).
// - action zero leaves output alone; nonzero takes over the pin when its direction bit is 1.
// - action change acts at next match; force strobe acts at once except in fast pwm modes.
`ifndef TMR16_CONSTS_VH
`define TMR16_CONSTS_VH
// ****************************************
// register offsets
// ****************************************
`define OFS_CTRL 4'h0
`define OFS_CNT 4'h1
`define OFS_CMPA 4'h2
`define OFS_CMPB 4'h3
`define OFS_CAP 4'h4
`define OFS_FLAGS 4'h5
`define OFS_FORCE 4'h6
// ****************************************
// control fields
// ****************************************
`define CTRL_MODE_LSB 0
`define CTRL_CS_LSB 4
`define CTRL_ACTA_LSB 8
`define CTRL_ACTB_LSB 10
`define CTRL_DIRA_BIT 12
`define CTRL_DIRB_BIT 13
`define CTRL_RESET 16'h0000
// ****************************************
// flag bits
// ****************************************
`define FLG_OVF 0
`define FLG_CMPA 1
`define FLG_CMPB 2
`define FLG_CAP 3
// ****************************************
// mode codes and fixed tops
// ****************************************
`define MODE_CTC_A 4'h4
`define MODE_F8 4'h5
`define MODE_F9 4'h6
`define MODE_F10 4'h7
`define MODE_CTC_C 4'hC
`define MODE_FCAP 4'hE
`define MODE_FA 4'hF
`define TOP_8 16'h00FF
`define TOP_9 16'h01FF
`define TOP_10 16'h03FF
`define CNT_MAX 16'hFFFF
`define DIV_8 10'h007
`define DIV_64 10'h03F
`define DIV_256 10'h0FF
`define DIV_1024 10'h3FF
`endif

/* tmr16_chk.sv */
// checker for the timer's bus and pin enables
`timescale 1ns/1ps
module tmr16_chk (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire [3:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [15:0] RDATA,
    input wire OUT_A,
    input wire OUT_A_OE_N,
    input wire OUT_B,
    input wire OUT_B_OE_N
);
    reg [3:0] mode_r;
    reg [1:0] acta_r;
    // mode and action A seen on control writes
    always @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mode_r <= 4'h0;
            acta_r <= 2'h0;
        end else if (WR && ADDR == 4'h0) begin
            mode_r <= WDATA[3:0];
            acta_r <= WDATA[9:8];
        end
    end
    default clocking dc @(posedge SYS_CLK); endclocking
    default disable iff (!ARST_N);
    sequence ctrl_wr_rd;
        WR && ADDR == 4'h0 ##1 RD && ADDR == 4'h0;
    endsequence
    sequence cmpb_wr_rd;
        WR && ADDR == 4'h3 && mode_r == 4'h5 ##1 RD && ADDR == 4'h3;
    endsequence
    chk_rdata_idle:
        assert property (!RD |=> RDATA == 16'h0000) else $error("data idle");
    chk_unmapped_read:
        assert property (RD && ADDR > 4'h6 |=> RDATA == 16'h0000)
        else $error("unmapped read");
    chk_pin_driven:
        assert property (WR && ADDR == 4'h0 && WDATA[12] &&
            WDATA[9:8] != 2'h0 |=> !OUT_A_OE_N) else $error("pin A idle");
    chk_pin_released:
        assert property (WR && ADDR == 4'h0 && !WDATA[12] |=> OUT_A_OE_N)
        else $error("pin A driven");
    chk_b_no_action:
        assert property (WR && ADDR == 4'h0 && WDATA[11:10] == 2'h0
            |=> OUT_B_OE_N) else $error("pin B driven");
    chk_ctrl_back:
        assert property (ctrl_wr_rd |=> (RDATA & 16'h3F7F) ==
            ($past(WDATA, 2) & 16'h3F7F)) else $error("control readback");
    chk_fixed_mask:
        assert property (cmpb_wr_rd |=> RDATA[15:8] == 8'h00)
        else $error("compare not masked");
    chk_out_hold:
        assert property (acta_r == 2'h0 [*3] |=> $stable(OUT_A))
        else $error("output A moved");
endmodule
bind tmr16_pwm tmr16_chk u_chk (.SYS_CLK, .ARST_N, .ADDR, .WDATA, .WR,
    .RD, .RDATA, .OUT_A, .OUT_A_OE_N, .OUT_B, .OUT_B_OE_N);

/* pin_load.sv */
// pull-up pin load that times one waveform pin
`timescale 1ns/1ps
module pin_load (
    input wire clk,
    input wire out,
    input wire oe_n,
    output wire pin,
    output reg [15:0] period = 16'h0000,
    output reg [15:0] high = 16'h0000
);
    reg [15:0] run_r = 16'h0000;
    reg [15:0] hi_r = 16'h0000;
    reg last_r = 1'b1;
    // released pin floats to the pull-up
    assign pin = oe_n ? 1'b1 : out;
    // cycles between rising edges and high cycles
    always @(posedge clk) begin
        last_r <= pin;
        if (pin && !last_r) begin
            period <= run_r;
            high <= hi_r;
            run_r <= 16'h0001;
            hi_r <= 16'h0001;
        end else begin
            run_r <= run_r + 16'h0001;
            hi_r <= hi_r + {15'h0000, pin};
        end
    end
endmodule

/* testbench.sv */
// self-checking bench for the 16-bit timer
`timescale 1ns/1ps
`include "tmr16_consts.vh"
module testbench;
    reg sys_clk = 1'b0;
    reg arst_n = 1'b0;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [3:0] addr = 4'h0;
    reg [15:0] wdata = 16'h0000;
    wire [15:0] rdata, per_a, hi_a, per_b, hi_b;
    wire out_a, oe_a_n, out_b, oe_b_n, pin_a, pin_b;
    integer n_fail = 0;
    integer compares = 0;
    integer i;
    always #2 sys_clk = ~sys_clk;
    tmr16_pwm DUT (.SYS_CLK(sys_clk), .ARST_N(arst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .OUT_A(out_a),
        .OUT_A_OE_N(oe_a_n), .OUT_B(out_b), .OUT_B_OE_N(oe_b_n));
    pin_load load_a (.clk(sys_clk), .out(out_a), .oe_n(oe_a_n),
        .pin(pin_a), .period(per_a), .high(hi_a));
    pin_load load_b (.clk(sys_clk), .out(out_b), .oe_n(oe_b_n),
        .pin(pin_b), .period(per_b), .high(hi_b));
    // ****
    // bus tasks
    // ****
    task check(input [15:0] got, input [15:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("unexpected at %0t: %h not %h", $time, got, exp);
            end
        end
    endtask
    task acc(input w, input [3:0] a, input [15:0] d);
        begin
            @(posedge sys_clk);
            wr <= w;
            rd <= ~w;
            addr <= a;
            wdata <= d;
        end
    endtask
    task idle;
        begin
            @(posedge sys_clk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
    endtask
    task wr_reg(input [3:0] a, input [15:0] d);
        begin
            acc(1'b1, a, d);
            idle;
        end
    endtask
    task rd_chk(input [3:0] a, input [15:0] e);
        begin
            acc(1'b0, a, 16'h0000);
            idle;
            #1 check(rdata, e);
        end
    endtask
    function [15:0] cw(input [3:0] m, input [2:0] s, input [1:0] a,
        input [1:0] b);
        cw = {4'h3, b, a, 1'b0, s, m};
    endfunction
    // stopped set-up, then 4*p+70 cycles of running
    task run(input [15:0] c, input [15:0] a, input [15:0] b,
        input [15:0] t, input [15:0] p);
        begin
            wr_reg(`OFS_CTRL, c & 16'hFF8F);
            wr_reg(`OFS_CNT, 16'h0000);
            wr_reg(`OFS_CMPA, a);
            wr_reg(`OFS_CMPB, b);
            wr_reg(`OFS_CAP, t);
            wr_reg(`OFS_FLAGS, 16'h000F);
            wr_reg(`OFS_CTRL, c);
            repeat (4 * p + 70) @(posedge sys_clk);
            wr_reg(`OFS_CTRL, c & 16'hFF8F);
        end
    endtask
    task print_verdict;
        begin
            $display("compares %0d mismatches %0d", compares, n_fail);
            if (n_fail == 0 && compares > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (6) @(posedge sys_clk);
        arst_n <= 1'b1;
        rd_chk(`OFS_FLAGS, 16'h0000);
        wr_reg(4'hF, 16'hFFFF);
        rd_chk(4'hF, 16'h0000);
        rd_chk(`OFS_CNT, 16'h0000);
        acc(1'b1, `OFS_CTRL, cw(4'hF, 3'h0, 2'h1, 2'h2));
        rd_chk(`OFS_CTRL, cw(4'hF, 3'h0, 2'h1, 2'h2));
        check({15'h0000, oe_a_n}, 16'h0000);
        for (i = 0; i < 3; i = i + 1) begin
            wr_reg(`OFS_CTRL, cw(4'h5 + i[3:0], 3'h0, 2'h0, 2'h0));
            #1 check({15'h0000, oe_a_n}, 16'h0001);
            acc(1'b1, `OFS_CMPB, 16'hFFFF);
            rd_chk(`OFS_CMPB, (16'h0100 << i) - 16'h0001);
        end
        $display("test registers done");
        run(cw(4'h4, 3'h1, 2'h1, 2'h0), 16'h0003, 16'h0100, 16'h0000, 8);
        check(per_a, 16'h0008);
        rd_chk(`OFS_FLAGS, 16'h0002);
        run(cw(4'h4, 3'h1, 2'h1, 2'h0), 16'h0000, 16'h0100, 16'h0000, 2);
        check(per_a, 16'h0002);
        run(cw(4'h4, 3'h2, 2'h1, 2'h0), 16'h0001, 16'h0100, 16'h0000, 32);
        check(per_a, 16'h0020);
        run(cw(4'hC, 3'h1, 2'h1, 2'h0), 16'h0001, 16'h0100, 16'h0004, 10);
        check(per_a, 16'h000A);
        rd_chk(`OFS_FLAGS, 16'h000A);
        wr_reg(`OFS_CNT, 16'h0020);
        wr_reg(`OFS_FLAGS, 16'h000F);
        wr_reg(`OFS_CTRL, cw(4'hC, 3'h1, 2'h1, 2'h0));
        repeat (40) @(posedge sys_clk);
        wr_reg(`OFS_CTRL, cw(4'hC, 3'h0, 2'h1, 2'h0));
        rd_chk(`OFS_FLAGS, 16'h0000);
        $display("test clear on match done");
        run(cw(4'hE, 3'h1, 2'h2, 2'h3), 16'h0003, 16'h0005, 16'h0009, 10);
        check(hi_a, 16'h0004);
        check(hi_b, 16'h0004);
        rd_chk(`OFS_FLAGS, 16'h000F);
        run(cw(4'hF, 3'h1, 2'h1, 2'h2), 16'h0004, 16'h0002, 16'h0000, 10);
        check(hi_a, 16'h0005);
        check(per_b, 16'h0005);
        for (i = 0; i < 3; i = i + 1) begin
            run(cw(4'h5 + i[3:0], 3'h1, 2'h2, 2'h2), 16'h003F, 16'h0000,
                16'h0000, 16'h0100 << i);
            check(per_a, 16'h0100 << i);
            check(hi_a, 16'h0040);
            check(hi_b, 16'h0001);
        end
        $display("test fast pwm done");
        print_verdict;
    end
endmodule
